// [cvc_regs.svh]
// register map, field positions and reset values of the comparator control bank
`ifndef CVC_REGS_SVH
`define CVC_REGS_SVH
// ----------------------------------------
// address map (byte addresses)
// ----------------------------------------
`define CVC_ADDR_W        8
`define CVC_ADDR_CMP_BASE 8'h00
`define CVC_ADDR_CMP_STEP 8'h04
`define CVC_ADDR_STAT     8'h0C
`define CVC_ADDR_REF      8'h10
`define CVC_MAX_CMP       3
// ----------------------------------------
// comparator control fields
// ----------------------------------------
`define CVC_CMP_INV_LSB    0
`define CVC_CMP_NONINV_BIT 4
`define CVC_CMP_OUT_BIT    8
`define CVC_CMP_EVT_BIT    9
`define CVC_CMP_WMASK      16'h0013
// ----------------------------------------
// status and reference fields
// ----------------------------------------
`define CVC_STAT_OUT_LSB   0
`define CVC_STAT_EVT_LSB   8
`define CVC_STAT_IDLE_BIT  15
`define CVC_REF_LEVEL_LSB  0
`define CVC_REF_SRC_BIT    4
`define CVC_REF_RANGE_BIT  5
`define CVC_REF_PINOE_BIT  6
`define CVC_REF_EN_BIT     7
`define CVC_REF_NEG_LSB    8
`define CVC_REF_POS_BIT    10
`define CVC_REF_WMASK      16'h07FF
`define CVC_REG_RESET      16'h0000
// ----------------------------------------
// bus responses
// ----------------------------------------
`define CVC_RESP_OKAY      2'h0
`define CVC_RESP_SLVERR    2'h2
`endif

// [cvc_pkg.sv]
// types shared by the comparator control bank modules
package cvc_pkg;
  // inverting input mux codes
  typedef enum logic [1:0] {
    cvc_inv_ext_b   = 2'h0,
    cvc_inv_ext_c   = 2'h1,
    cvc_inv_ext_d   = 2'h2,
    cvc_inv_int_neg = 2'h3
  } cvc_inv_sel_t;
  // one comparator channel state
  typedef struct packed {
    logic         noninv;
    cvc_inv_sel_t inv;
    logic         s1;
    logic         s2;
    logic         s3;
    logic         out;
    logic         evt;
  } cvc_chan_state_t;
  // bus slave and shared register state
  typedef struct packed {
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [15:0] w_data;
    logic [1:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        idle_stop;
    logic        halt;
    logic [15:0] ref_ctrl;
  } cvc_top_state_t;
endpackage

// [cvc_chan_if.sv]
// link between the register decoder and one comparator channel
`timescale 1ns/10ps
interface cvc_chan_if;
  logic        wr;     // write pulse to this channel
  logic [15:0] wdata;  // write data
  logic [15:0] wmask;  // byte lane mask
  logic        run;    // comparator allowed to run
  logic [15:0] rdata;  // readback word
  logic        noninv; // non-inverting select
  logic [1:0]  inv;    // inverting select
  logic        out;    // settled output
  logic        evt;    // sticky event
  modport regs (output wr, wdata, wmask, run, input rdata, noninv, inv, out, evt);
  modport chan (input wr, wdata, wmask, run, output rdata, noninv, inv, out, evt);
endinterface

// [cvc_chan.sv]
// one comparator channel: input selects, output synchroniser and event flag
`timescale 1ns/10ps
`include "cvc_regs.svh"
module cvc_chan
  import cvc_pkg::*;
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // raw comparator output from the analog side
  input  wire logic cmp_raw_i,
  // register side
  cvc_chan_if.chan  bus
);
  cvc_chan_state_t st_reg;  // registered state
  cvc_chan_state_t st_next; // next state
  logic            chg;     // settled output changed
  logic            clr;     // software clears event

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    chg     = 1'b0;
    // three stage synchroniser, s1 feeds only s2
    st_next.s1 = cmp_raw_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // accept a change once the second and third stages agree
    if (bus.run && st_reg.s2 == st_reg.s3 && st_reg.s3 != st_reg.out) begin
      st_next.out = st_reg.s3;
      chg         = 1'b1;
    end
    // writing zero to the event bit clears it
    clr = bus.wr && bus.wmask[`CVC_CMP_EVT_BIT] && !bus.wdata[`CVC_CMP_EVT_BIT];
    // set beats clear
    if (chg) begin
      st_next.evt = 1'b1;
    end else if (clr) begin
      st_next.evt = 1'b0;
    end
    // writable select fields
    if (bus.wr && bus.wmask[`CVC_CMP_NONINV_BIT]) begin
      st_next.noninv = bus.wdata[`CVC_CMP_NONINV_BIT];
    end
    if (bus.wr && bus.wmask[`CVC_CMP_INV_LSB]) begin
      st_next.inv = cvc_inv_sel_t'(bus.wdata[`CVC_CMP_INV_LSB +: 2]);
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // readback, bits 3..2 and the rest stay zero
  always_comb begin
    bus.rdata                      = `CVC_REG_RESET;
    bus.rdata[`CVC_CMP_EVT_BIT]    = st_reg.evt;
    bus.rdata[`CVC_CMP_OUT_BIT]    = st_reg.out;
    bus.rdata[`CVC_CMP_NONINV_BIT] = st_reg.noninv;
    bus.rdata[`CVC_CMP_INV_LSB +: 2] = st_reg.inv;
  end
  assign bus.noninv = st_reg.noninv;
  assign bus.inv    = st_reg.inv;
  assign bus.out    = st_reg.out;
  assign bus.evt    = st_reg.evt;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  noninv_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    bus.wr && bus.wmask[`CVC_CMP_NONINV_BIT]
    |=> bus.noninv == $past(bus.wdata[`CVC_CMP_NONINV_BIT]))
    else $error("non-inverting select not taken");
  inv_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    bus.wr && bus.wmask[`CVC_CMP_INV_LSB]
    |=> bus.inv == $past(bus.wdata[`CVC_CMP_INV_LSB +: 2]))
    else $error("inverting select not taken");
  unimpl_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
    bus.rdata[3:2] == 2'h0)
    else $error("unimplemented control bits not zero");
endmodule // cvc_chan

// [cvc_regs_top.sv]
// comparator control and status register bank with reference control, AXI4-Lite slave
`timescale 1ns/10ps
`include "cvc_regs.svh"
module cvc_regs_top
  import cvc_pkg::*;
#(
  parameter int NUM_CMP = 3 // comparators in the bank
) (
  // clock and reset
  input  wire logic                         clock_i,
  input  wire logic                         rst_i,
  // write address channel
  input  wire logic                         s_axi_awvalid_i,
  output logic                              s_axi_awready_o,
  input  wire logic [`CVC_ADDR_W-1:0]       s_axi_awaddr_i,
  // write data channel
  input  wire logic                         s_axi_wvalid_i,
  output logic                              s_axi_wready_o,
  input  wire logic [31:0]                  s_axi_wdata_i,
  input  wire logic [3:0]                   s_axi_wstrb_i,
  // write response channel
  output logic                              s_axi_bvalid_o,
  input  wire logic                         s_axi_bready_i,
  output logic [1:0]                        s_axi_bresp_o,
  // read address channel
  input  wire logic                         s_axi_arvalid_i,
  output logic                              s_axi_arready_o,
  input  wire logic [`CVC_ADDR_W-1:0]       s_axi_araddr_i,
  // read data channel
  output logic                              s_axi_rvalid_o,
  input  wire logic                         s_axi_rready_i,
  output logic [31:0]                       s_axi_rdata_o,
  output logic [1:0]                        s_axi_rresp_o,
  // chip power state
  input  wire logic                         idle_mode_i,
  // analog comparators
  input  wire logic [NUM_CMP-1:0]           cmp_raw_i,
  output logic [NUM_CMP-1:0]                cmp_run_o,
  output logic [NUM_CMP-1:0]                noninv_input_select_o,
  output logic [2*NUM_CMP-1:0]              inverting_channel_select_o,
  // reference ladder
  output logic [3:0]                        ref_level_code_o,
  output logic                              ref_source_select_o,
  output logic                              ref_range_select_o,
  output logic                              ref_pin_output_enable_o,
  output logic                              ref_ladder_enable_o,
  output logic                              neg_ref_route_lo_o,
  output logic                              neg_ref_route_hi_o,
  output logic                              pos_ref_route_o
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  // the address map has room for three comparator words only; a fourth would land on the status word at 0x0C
  if (NUM_CMP < 1 || NUM_CMP > `CVC_MAX_CMP) begin : g_bad_num
    $error("NUM_CMP must be 1 to 3");
  end

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  cvc_top_state_t    st_reg;              // registered state
  cvc_top_state_t    st_next;             // next state
  logic              wr_fire;             // held address and data meet
  logic              rd_fire;             // read address taken
  logic [15:0]       rd_word;             // selected read word
  logic              rd_hit;              // read address mapped
  logic              wr_hit;              // write address mapped
  logic [15:0]       wr_mask;             // byte lanes as a bit mask
  logic [15:0]       ref_mask;            // writable reference bits this write
  logic [15:0]       stat_word;           // assembled status word
  logic [`CVC_ADDR_W-1:0] rd_addr;        // aligned read address
  logic [`CVC_ADDR_W-1:0] wr_addr;        // aligned write address
  logic [15:0]       ch_rdata [NUM_CMP];  // channel readback words
  logic [NUM_CMP-1:0] ch_evt;             // channel event flags
  logic [NUM_CMP-1:0] ch_out;             // channel outputs
  logic [NUM_CMP-1:0] ch_wr;              // channel write pulses

  cvc_chan_if ch [NUM_CMP] ();            // one link per channel

  // ----------------------------------------
  // channel address decode
  // ----------------------------------------
  // byte address of a channel's control word
  function automatic logic [`CVC_ADDR_W-1:0] cmp_addr(input int idx);
    cmp_addr = `CVC_ADDR_CMP_BASE + `CVC_ADDR_W'(idx) * `CVC_ADDR_CMP_STEP;
  endfunction

  // low address bits are ignored, every register is one word
  assign rd_addr = {s_axi_araddr_i[`CVC_ADDR_W-1:2], 2'h0};
  assign wr_addr = {st_reg.aw_addr[`CVC_ADDR_W-1:2], 2'h0};
  assign wr_mask = {{8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};
  assign ref_mask = wr_mask & `CVC_REF_WMASK;

  // ----------------------------------------
  // channels
  // ----------------------------------------
  for (genvar g = 0; g < NUM_CMP; g++) begin : g_chan
    // write pulse only when the held address names this channel
    assign ch_wr[g]       = wr_fire && wr_addr == cmp_addr(g);
    assign ch[g].wr       = ch_wr[g];
    assign ch[g].wdata    = st_reg.w_data;
    assign ch[g].wmask    = wr_mask;
    assign ch[g].run      = !st_reg.halt;
    assign ch_rdata[g]    = ch[g].rdata;
    assign ch_evt[g]      = ch[g].evt;
    assign ch_out[g]      = ch[g].out;
    // input mux steering to the analog side
    assign noninv_input_select_o[g]           = ch[g].noninv;
    assign inverting_channel_select_o[2*g +: 2] = ch[g].inv;
    assign cmp_run_o[g]   = !st_reg.halt;

    cvc_chan u_chan (
      .clock_i   (clock_i),
      .rst_i     (rst_i),
      .cmp_raw_i (cmp_raw_i[g]),
      .bus       (ch[g])
    );
  end

  // ----------------------------------------
  // status word
  // ----------------------------------------
  // channel mirrors plus the writable idle-stop bit; unused bits stay zero
  always_comb begin
    stat_word = `CVC_REG_RESET;
    stat_word[`CVC_STAT_IDLE_BIT] = st_reg.idle_stop;
    for (int i = 0; i < NUM_CMP; i++) begin
      stat_word[`CVC_STAT_EVT_LSB + i] = ch_evt[i];
      stat_word[`CVC_STAT_OUT_LSB + i] = ch_out[i];
    end
  end

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  always_comb begin
    rd_word = `CVC_REG_RESET;
    rd_hit  = 1'b0;
    // comparator control words
    for (int i = 0; i < NUM_CMP; i++) begin
      if (rd_addr == cmp_addr(i)) begin
        rd_word = ch_rdata[i];
        rd_hit  = 1'b1;
      end
    end
    // status and reference words
    if (rd_addr == `CVC_ADDR_STAT) begin
      rd_word = stat_word;
      rd_hit  = 1'b1;
    end else if (rd_addr == `CVC_ADDR_REF) begin
      rd_word = st_reg.ref_ctrl;
      rd_hit  = 1'b1;
    end
  end

  // write address is mapped
  always_comb begin
    wr_hit = (wr_addr == `CVC_ADDR_STAT) || (wr_addr == `CVC_ADDR_REF);
    for (int i = 0; i < NUM_CMP; i++) begin
      if (wr_addr == cmp_addr(i)) begin
        wr_hit = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // handshakes
  // ----------------------------------------
  // one write and one read at a time; ready drops while a response waits
  // so that a second request cannot overwrite the held half or the answer
  assign s_axi_awready_o = !st_reg.aw_held && !st_reg.bvalid;
  assign s_axi_wready_o  = !st_reg.w_held && !st_reg.bvalid;
  assign s_axi_arready_o = !st_reg.rvalid;
  assign wr_fire = st_reg.aw_held && st_reg.w_held;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    // catch write address
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr_i;
    end
    // catch write data, low half word only
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata_i[15:0];
      st_next.w_strb = s_axi_wstrb_i[1:0];
    end
    // response taken
    if (st_reg.bvalid && s_axi_bready_i) begin
      st_next.bvalid = 1'b0;
    end
    // perform the write once both halves are held
    if (wr_fire) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = wr_hit ? `CVC_RESP_OKAY : `CVC_RESP_SLVERR;
      // only the idle-stop bit of the status word is writable
      if (wr_addr == `CVC_ADDR_STAT && wr_mask[`CVC_STAT_IDLE_BIT]) begin
        st_next.idle_stop = st_reg.w_data[`CVC_STAT_IDLE_BIT];
      end
      // reference word, upper bits never stored
      if (wr_addr == `CVC_ADDR_REF) begin
        st_next.ref_ctrl = (st_reg.w_data & ref_mask)
                         | (st_reg.ref_ctrl & ~ref_mask);
      end
    end
    // read data taken
    if (st_reg.rvalid && s_axi_rready_i) begin
      st_next.rvalid = 1'b0;
    end
    // read address taken, data appears next cycle
    if (rd_fire) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = {16'h0000, rd_word};
      st_next.rresp  = rd_hit ? `CVC_RESP_OKAY : `CVC_RESP_SLVERR;
    end
    // halt comparators while idle if so asked
    st_next.halt = idle_mode_i && st_reg.idle_stop;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // every field clears to zero at reset
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // bus answers
  assign s_axi_bvalid_o = st_reg.bvalid;
  assign s_axi_bresp_o  = st_reg.bresp;
  assign s_axi_rvalid_o = st_reg.rvalid;
  assign s_axi_rdata_o  = st_reg.rdata;
  assign s_axi_rresp_o  = st_reg.rresp;
  // reference ladder controls
  // the ladder sees a new field one cycle after the write is performed
  assign ref_level_code_o        = st_reg.ref_ctrl[`CVC_REF_LEVEL_LSB +: 4];
  assign ref_source_select_o     = st_reg.ref_ctrl[`CVC_REF_SRC_BIT];
  assign ref_range_select_o      = st_reg.ref_ctrl[`CVC_REF_RANGE_BIT];
  assign ref_pin_output_enable_o = st_reg.ref_ctrl[`CVC_REF_PINOE_BIT];
  assign ref_ladder_enable_o     = st_reg.ref_ctrl[`CVC_REF_EN_BIT];
  assign neg_ref_route_lo_o      = st_reg.ref_ctrl[`CVC_REF_NEG_LSB];
  assign neg_ref_route_hi_o      = st_reg.ref_ctrl[`CVC_REF_NEG_LSB + 1];
  assign pos_ref_route_o         = st_reg.ref_ctrl[`CVC_REF_POS_BIT];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // idle halt follows one cycle after idle and idle-stop meet
  idle_halt_a: assert property (
    idle_mode_i && st_reg.idle_stop |=> cmp_run_o == '0)
    else $error("comparators not halted in idle");
  idle_run_a: assert property (
    !idle_mode_i || !st_reg.idle_stop |=> cmp_run_o == '1)
    else $error("comparators halted without cause");
  // status read returns the mirrors sampled at the address edge
  stat_evt_mirror_a: assert property (
    rd_fire && rd_addr == `CVC_ADDR_STAT
    |=> s_axi_rdata_o[`CVC_STAT_EVT_LSB +: NUM_CMP] == $past(ch_evt))
    else $error("status event mirror wrong");
  stat_out_mirror_a: assert property (
    rd_fire && rd_addr == `CVC_ADDR_STAT
    |=> s_axi_rdata_o[`CVC_STAT_OUT_LSB +: NUM_CMP] == $past(ch_out))
    else $error("status output mirror wrong");
  stat_zero_bits_a: assert property (
    rd_fire && rd_addr == `CVC_ADDR_STAT
    |=> s_axi_rdata_o[14:11] == 4'h0 && s_axi_rdata_o[7:3] == 5'h00)
    else $error("status unused bits not zero");
  // a status write never reaches a channel, so the write cannot move the mirrors
  stat_ro_write_a: assert property (
    wr_fire && wr_addr == `CVC_ADDR_STAT |-> ch_wr == '0)
    else $error("status write disturbed mirror");
  ref_upper_zero_a: assert property (
    rd_fire && rd_addr == `CVC_ADDR_REF |=> s_axi_rdata_o[15:11] == 5'h00)
    else $error("reference upper bits not zero");
  // reference fields take the written value on the cycle after the write
  ref_range_a: assert property (
    wr_fire && wr_addr == `CVC_ADDR_REF && st_reg.w_strb[0]
    |=> ref_range_select_o == $past(st_reg.w_data[`CVC_REF_RANGE_BIT]))
    else $error("range select not taken");
  ref_level_a: assert property (
    wr_fire && wr_addr == `CVC_ADDR_REF && st_reg.w_strb[0]
    |=> ref_level_code_o == $past(st_reg.w_data[`CVC_REF_LEVEL_LSB +: 4]))
    else $error("level code not taken");
  ref_source_a: assert property (
    wr_fire && wr_addr == `CVC_ADDR_REF && st_reg.w_strb[0]
    |=> ref_source_select_o == $past(st_reg.w_data[`CVC_REF_SRC_BIT]))
    else $error("source select not taken");
  ref_source_hold_a: assert property (
    !(wr_fire && wr_addr == `CVC_ADDR_REF) |=> $stable(ref_source_select_o))
    else $error("source select moved without write");
  // reference fields hold between writes
  ref_level_hold_a: assert property (
    !(wr_fire && wr_addr == `CVC_ADDR_REF) |=> $stable(ref_level_code_o))
    else $error("level code moved without write");
  ref_range_hold_a: assert property (
    !(wr_fire && wr_addr == `CVC_ADDR_REF) |=> $stable(ref_range_select_o))
    else $error("range select moved without write");
  // idle-stop is the only writable status bit and reads back as held
  idle_stop_write_a: assert property (
    wr_fire && wr_addr == `CVC_ADDR_STAT && wr_mask[`CVC_STAT_IDLE_BIT]
    |=> st_reg.idle_stop == $past(st_reg.w_data[`CVC_STAT_IDLE_BIT]))
    else $error("idle-stop bit not taken");
  stat_idle_read_a: assert property (
    rd_fire && rd_addr == `CVC_ADDR_STAT
    |=> s_axi_rdata_o[`CVC_STAT_IDLE_BIT] == $past(st_reg.idle_stop))
    else $error("idle-stop bit read back wrong");
endmodule // cvc_regs_top

// [cvc_analog_model.sv]
// behavioural model of the three analog comparators behind the bank
`timescale 1ns/10ps
module cvc_analog_model (
  // level each comparator should settle to
  input  wire logic [2:0] level_i,
  // raw comparator outputs, changing off the clock grid
  output logic      [2:0] cmp_raw_o
);
  // ----------------------------------------
  // analog settling
  // ----------------------------------------
  // outputs follow the level after a short delay, unrelated to the clock
  initial begin
    cmp_raw_o = 3'h0;
    forever begin
      @(level_i);
      cmp_raw_o <= #3 level_i;
    end
  end
endmodule // cvc_analog_model

// [cvc_regs_top_tb_top.sv]
// self-checking bench of the comparator control bank with a register model
`timescale 1ns/10ps
module cvc_regs_top_tb_top;
  import cvc_pkg::*;
  // ----------------------------------------
  // bench signals
  // ----------------------------------------
  logic        clock_i = 1'b0;  // system clock
  logic        rst_i   = 1'b1;  // reset, held at start
  logic        awvalid = 1'b0;  // bus master requests
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        idle    = 1'b0;  // chip idle state
  logic [2:0]  level   = 3'h0;  // analog levels asked of the model
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  raw, run, noninv;
  logic [5:0]  invsel;
  logic [10:0] ref_out;         // reference outputs in register bit order
  int          error_cnt = 0;   // mismatches
  int          checked   = 0;   // comparisons
  int          m_cmp[3] = '{0, 0, 0};  // model: written control fields
  int          m_out[3] = '{0, 0, 0};  // model: settled outputs
  int          m_evt[3] = '{0, 0, 0};  // model: sticky events
  int          m_idle = 0;
  int          m_ref  = 0;
  // ----------------------------------------
  // clock, design and partner
  // ----------------------------------------
  initial forever #5 clock_i = ~clock_i;
  cvc_regs_top i_dut (.clock_i(clock_i), .rst_i(rst_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .idle_mode_i(idle),
    .cmp_raw_i(raw), .cmp_run_o(run), .noninv_input_select_o(noninv),
    .inverting_channel_select_o(invsel), .ref_level_code_o(ref_out[3:0]),
    .ref_source_select_o(ref_out[4]), .ref_range_select_o(ref_out[5]),
    .ref_pin_output_enable_o(ref_out[6]), .ref_ladder_enable_o(ref_out[7]),
    .neg_ref_route_lo_o(ref_out[8]), .neg_ref_route_hi_o(ref_out[9]),
    .pos_ref_route_o(ref_out[10]));
  cvc_analog_model i_analog (.level_i(level), .cmp_raw_o(raw));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // expected read word, built from the model
  function automatic logic [31:0] exp_rd(input int a);
    case (a)
      0, 4, 8: return 32'(m_cmp[a/4] | (m_out[a/4] << 8) | (m_evt[a/4] << 9));
      12: return 32'((m_idle << 15) | (m_evt[2] << 10) | (m_evt[1] << 9) | (m_evt[0] << 8)
                     | (m_out[2] << 2) | (m_out[1] << 1) | m_out[0]);
      16: return 32'(m_ref);
      default: return 32'h0;  // unmapped reads zero
    endcase
  endfunction
  // ----------------------------------------
  // bus master tasks
  // ----------------------------------------
  // one write; the model follows once the response is in
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (bvalid !== 1'b1) error_cnt++;  // no response within the limit
    chk(bresp, er);
    case (a)
      0, 4, 8: begin
        m_cmp[a/4] = int'(d & 32'h13);
        m_evt[a/4] = m_evt[a/4] & int'(d[9]);  // writing zero clears the event
      end
      12: m_idle = int'(d[15]);
      16: m_ref = int'(d & 32'h7FF);
      default: ;  // unmapped: nothing changes
    endcase
  endtask
  // one read, compared with the model
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    if (rvalid !== 1'b1) error_cnt++;  // no read data within the limit
    chk(rresp, er);
    chk(rdata, exp_rd(int'(a)));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    void'($urandom(42));
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 16; a += 4) axi_rd(8'(a), 2'h0);
    // every inverting code on every comparator, reserved bits random, event bit written as zero
    for (int g = 0; g < 3; g++) begin
      for (int c = 0; c < 4; c++) begin
        d = ($urandom & 32'hFFFF_FDFC) | 32'(c);
        axi_wr(8'(4 * g), d, 2'h0);
        repeat (2) @(posedge clock_i);
        chk(32'(noninv[g]), 32'(d[4]));
        chk(32'(invsel[2*g+:2]), 32'(c));
        axi_rd(8'(4 * g), 2'h0);
      end
    end
    // reference word with random fields
    repeat (8) begin
      axi_wr(8'h10, $urandom, 2'h0);
      repeat (2) @(posedge clock_i);
      chk(32'(ref_out), 32'(m_ref));
      axi_rd(8'h10, 2'h0);
    end
    // writes to the mirrors are ignored; idle-stop halts and freezes
    axi_wr(8'h0C, 32'hFFFF, 2'h0);
    axi_rd(8'h0C, 2'h0);
    idle <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk(32'(run), 32'h0);
    level <= 3'h2;
    repeat (8) @(posedge clock_i);
    axi_rd(8'h04, 2'h0);
    idle <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk(32'(run), 32'h7);
    repeat (8) @(posedge clock_i);
    m_out[1] = 1;
    m_evt[1] = 1;
    axi_rd(8'h04, 2'h0);
    axi_wr(8'h0C, 32'h0, 2'h0);
    axi_rd(8'h0C, 2'h0);
    idle <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk(32'(run), 32'h7);
    axi_wr(8'h04, 32'h0, 2'h0);
    axi_rd(8'h0C, 2'h0);
    idle <= 1'b0;
    // unmapped place answers with an error and reads zero
    axi_wr(8'h14, $urandom, 2'h2);
    axi_rd(8'h14, 2'h2);
    give_verdict();
  end
  // hang guard, far beyond the length of the run
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    give_verdict();
  end
endmodule // cvc_regs_top_tb_top
